// file: include/mcb_pkg.sv
// package for the card-side bus transfer block
package mcb_pkg;
  localparam int unsigned REF_CLK_MHZ = 100;
  localparam int unsigned CMD_BITS = 48;
  localparam int unsigned CRC7_W = 7;
  // link timing, in link clock cycles
  localparam int unsigned IDENTIFICATION_RESPONSE_DELAY = 5;
  localparam int unsigned COMMAND_TO_RESPONSE_DELAY = 2;
  localparam int unsigned RESPONSE_TO_COMMAND_GAP = 8;
  localparam int unsigned COMMAND_TO_COMMAND_GAP = 8;
  localparam int unsigned READ_ACCESS_DELAY_MIN = 2;
  localparam int unsigned BUSY_START_DELAY = 2;
  localparam int unsigned STOP_DATA_DELAY = 2;
  localparam int unsigned Z_BITS = 2;
  localparam int unsigned ACCESS_MULT = 10;
  localparam int unsigned FACTOR_MULT = 100;
  // command indices
  localparam logic [5:0] CMD_SEND_OP_COND = 6'h01;
  localparam logic [5:0] CMD_ALL_SEND_ID = 6'h02;
  localparam logic [5:0] CMD_SET_ADDR = 6'h03;
  localparam logic [5:0] CMD_SWITCH = 6'h06;
  localparam logic [5:0] CMD_SELECT = 6'h07;
  localparam logic [5:0] CMD_STOP = 6'h0c;
  localparam logic [5:0] CMD_STATUS = 6'h0d;
  localparam logic [5:0] CMD_BLOCKLEN = 6'h10;
  localparam logic [5:0] CMD_READ_SINGLE = 6'h11;
  localparam logic [5:0] CMD_READ_MULTI = 6'h12;
  localparam logic [5:0] CMD_BUS_TEST = 6'h13;
  localparam logic [5:0] CMD_WRITE_SINGLE = 6'h18;
  localparam logic [5:0] CMD_WRITE_MULTI = 6'h19;
  localparam logic [5:0] CMD_ERASE_START = 6'h23;
  localparam logic [5:0] CMD_ERASE_END = 6'h24;
  localparam logic [5:0] CMD_ERASE = 6'h26;
  localparam logic [5:0] CMD_WP_SET = 6'h1c;
  localparam logic [5:0] CMD_WP_CLR = 6'h1d;
  localparam logic [2:0] TOKEN_GOOD = 3'h2;
  localparam logic [2:0] TOKEN_BAD = 3'h5;
  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
  } mcb_cmd_t;
  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
  } mcb_resp_t;
  typedef struct packed {
    logic o;
    logic oe;
  } mcb_pin_t;
endpackage

// file: verilog/mcb_card.sv
// card-side command and data line engine for a host-clocked flash card bus
`timescale 1ns/1ps
module mcb_card #(
  parameter int unsigned BLOCK_BYTES = 512,
  parameter int unsigned ACCESS_CYCLES = 2,
  parameter int unsigned PROG_CYCLES = 64,
  parameter int unsigned ERASE_GROUP_BLOCKS = 16,
  parameter int unsigned WP_GROUP_GROUPS = 4,
  parameter int unsigned MEM_BYTES = 1024
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic link_clk, // host-supplied link clock
  input wire logic cmd_i, // command line level
  output mcb_pkg::mcb_pin_t cmd_pin, // command line drive
  input wire logic dat0_i, // data0 line level
  output mcb_pkg::mcb_pin_t dat0_pin, // data0 line drive
  output logic busy, // card programming, system domain
  output logic [3:0] card_state // card state, system domain
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_READY, ST_IDENT, ST_STBY, ST_TRAN, ST_DATA, ST_RCV, ST_PRG, ST_DIS
  } mcb_state_t;
  typedef enum logic [2:0] {
    DS_IDLE, DS_WAIT, DS_SEND, DS_RECV, DS_TOKEN, DS_TAIL, DS_BUSY
  } mcb_dat_t;

  // ---------------------------------------------------------------
  // link reset crossing
  // ---------------------------------------------------------------
  logic lrst_a_reg, lrst_n_reg;
  always_ff @(posedge link_clk) begin
    lrst_a_reg <= rst_n;
    lrst_n_reg <= lrst_a_reg;
  end

  function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
    logic fb;
    fb = c[6] ^ b;
    crc7_step = {c[5:3], c[2] ^ fb, c[1:0], fb};
  endfunction
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    crc16_step = {c[14:12], c[11] ^ fb, c[10:5], c[4] ^ fb, c[3:0], fb};
  endfunction

  // ---------------------------------------------------------------
  // command receiver
  // ---------------------------------------------------------------
  logic [47:0] sh_reg;
  logic [5:0] cnt_reg;
  logic [6:0] crc_reg;
  logic rx_act_reg, cmd_done, cmd_ok;
  logic [5:0] cidx;
  logic [31:0] carg;
  logic drive_cmd;
  assign cidx = sh_reg[45:40];
  assign carg = sh_reg[39:8];
  always_ff @(posedge link_clk) begin
    cmd_done <= 1'b0;
    if (!lrst_n_reg) begin
      rx_act_reg <= 1'b0;
      cnt_reg <= 6'h00;
      sh_reg <= '0;
      crc_reg <= 7'h00;
      cmd_ok <= 1'b0;
    end else if (!rx_act_reg) begin
      if (!cmd_i && !drive_cmd) begin
        rx_act_reg <= 1'b1;
        cnt_reg <= 6'h01;
        sh_reg <= 48'h0;
        crc_reg <= crc7_step(7'h00, 1'b0);
      end
    end else begin
      sh_reg <= {sh_reg[46:0], cmd_i};
      cnt_reg <= cnt_reg + 6'h01;
      if (cnt_reg < 6'd40)
        crc_reg <= crc7_step(crc_reg, cmd_i);
      if (cnt_reg == 6'd47) begin
        rx_act_reg <= 1'b0;
        cmd_done <= 1'b1;
        // transmitter bit, crc and end bit checked
        cmd_ok <= sh_reg[45] && (sh_reg[6:0] == crc_reg) && cmd_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // card state and response engine
  // ---------------------------------------------------------------
  mcb_state_t st_reg;
  logic [47:0] tx_reg;
  logic [7:0] tx_cnt_reg, wait_reg;
  logic tx_od_reg, tx_act_reg, rsp_busy_reg, ab_reg;
  logic [6:0] tcrc_reg;
  logic prog_busy_q;
  logic start_read_reg, start_write_reg, multi_reg, stop_reg, prog_req_reg;
  logic [15:0] rca_reg;
  logic [31:0] addr_reg;
  mcb_pkg::mcb_pin_t cmd_d;
  wire is_id = (cidx == mcb_pkg::CMD_SEND_OP_COND) || (cidx == mcb_pkg::CMD_ALL_SEND_ID);
  // stop seen one cycle ahead of stop_reg so data ends two cycles after the end bit
  wire stop_now = cmd_done && cmd_ok && !tx_act_reg && (cidx == mcb_pkg::CMD_STOP);
  always_ff @(posedge link_clk) begin
    start_read_reg <= 1'b0;
    start_write_reg <= 1'b0;
    stop_reg <= 1'b0;
    prog_req_reg <= 1'b0;
    if (!lrst_n_reg) begin
      st_reg <= ST_IDLE;
      tx_act_reg <= 1'b0;
      tx_reg <= '0;
      tx_cnt_reg <= 8'h00;
      wait_reg <= 8'h00;
      tx_od_reg <= 1'b1;
      tcrc_reg <= 7'h00;
      rsp_busy_reg <= 1'b0;
      multi_reg <= 1'b0;
      rca_reg <= 16'h0000;
      addr_reg <= '0;
      ab_reg <= 1'b0;
    end else if (cmd_done && cmd_ok && !tx_act_reg) begin
      tx_act_reg <= 1'b1;
      tx_reg <= {1'b0, 1'b0, cidx, carg, 8'h01};
      tcrc_reg <= 7'h00;
      tx_cnt_reg <= 8'h00;
      rsp_busy_reg <= 1'b0;
      tx_od_reg <= (st_reg < ST_STBY);
      // decode and output register each cost one cycle of the delay
      if (is_id)
        wait_reg <= 8'(mcb_pkg::IDENTIFICATION_RESPONSE_DELAY - 2);
      else if (cidx == mcb_pkg::CMD_SET_ADDR)
        wait_reg <= 8'(mcb_pkg::COMMAND_TO_RESPONSE_DELAY - 2);
      else
        wait_reg <= 8'(mcb_pkg::COMMAND_TO_RESPONSE_DELAY - 1);
      unique case (cidx)
        mcb_pkg::CMD_SEND_OP_COND: st_reg <= ST_READY;
        mcb_pkg::CMD_ALL_SEND_ID: st_reg <= ST_IDENT;
        mcb_pkg::CMD_SET_ADDR: begin
          st_reg <= ST_STBY;
          rca_reg <= carg[31:16];
        end
        mcb_pkg::CMD_SELECT: begin
          ab_reg <= (carg[31:16] == rca_reg);
          if (carg[31:16] == rca_reg)
            st_reg <= prog_busy_q ? ST_PRG : ST_TRAN;
          else if (st_reg == ST_PRG)
            st_reg <= ST_DIS;
          else
            st_reg <= ST_STBY;
          rsp_busy_reg <= (carg[31:16] == rca_reg) && prog_busy_q;
        end
        mcb_pkg::CMD_READ_SINGLE, mcb_pkg::CMD_READ_MULTI: begin
          st_reg <= ST_DATA;
          addr_reg <= carg;
          multi_reg <= (cidx == mcb_pkg::CMD_READ_MULTI);
          start_read_reg <= 1'b1;
        end
        mcb_pkg::CMD_WRITE_SINGLE, mcb_pkg::CMD_WRITE_MULTI: begin
          st_reg <= ST_RCV;
          addr_reg <= carg;
          multi_reg <= (cidx == mcb_pkg::CMD_WRITE_MULTI);
          start_write_reg <= 1'b1;
        end
        mcb_pkg::CMD_STOP: begin
          stop_reg <= 1'b1;
          rsp_busy_reg <= 1'b1;
          st_reg <= ST_TRAN;
        end
        mcb_pkg::CMD_ERASE, mcb_pkg::CMD_WP_SET, mcb_pkg::CMD_WP_CLR, mcb_pkg::CMD_SWITCH: begin
          prog_req_reg <= 1'b1;
          st_reg <= ST_PRG;
          rsp_busy_reg <= 1'b1;
        end
        default: ;
      endcase
    end else if (tx_act_reg) begin
      if (wait_reg != 8'h00)
        wait_reg <= wait_reg - 8'h01;
      else begin
        tx_cnt_reg <= tx_cnt_reg + 8'h01;
        tx_reg <= {tx_reg[46:0], 1'b1};
        if (tx_cnt_reg < 8'd40)
          tcrc_reg <= crc7_step(tcrc_reg, tx_reg[47]);
        if (tx_cnt_reg == 8'd39)
          tx_reg[47:40] <= {crc7_step(tcrc_reg, tx_reg[47]), 1'b1};
        if (tx_cnt_reg == 8'd47)
          tx_act_reg <= 1'b0;
      end
      if (st_reg == ST_PRG && !prog_busy_q && !rsp_busy_reg)
        st_reg <= ST_TRAN;
    end else if ((st_reg == ST_PRG) && !prog_busy_q)
      st_reg <= ST_TRAN;
  end

  // command line drive, updated on the rising link edge
  always_comb begin
    cmd_d.o = 1'b1;
    cmd_d.oe = 1'b0;
    if (tx_act_reg) begin
      if (wait_reg == 8'h00) begin
        cmd_d.o = tx_reg[47];
        cmd_d.oe = tx_od_reg ? !tx_reg[47] : 1'b1;
      end else if (!tx_od_reg) begin
        // pull-up bit after the two z bits
        cmd_d.o = 1'b1;
        cmd_d.oe = 1'b1;
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (!lrst_n_reg)
      cmd_pin <= '{o: 1'b1, oe: 1'b0};
    else
      cmd_pin <= cmd_d;
  end
  assign drive_cmd = tx_act_reg;

  // ---------------------------------------------------------------
  // data line engine
  // ---------------------------------------------------------------
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rxb [BLOCK_BYTES];
  logic [31:0] boff_reg;
  mcb_dat_t ds_reg;
  logic [31:0] dcnt_reg;
  logic [15:0] dcrc_reg;
  logic [7:0] byte_reg;
  logic [2:0] tok_reg;
  logic buf_full_reg, buf_good_reg, stop_pend_reg;
  logic [31:0] pcnt_reg;
  localparam int unsigned BLK_BITS = BLOCK_BYTES * 8;
  wire [31:0] maddr = (addr_reg + boff_reg + (dcnt_reg >> 3)) % MEM_BYTES;
  always_ff @(posedge link_clk) begin
    if (!lrst_n_reg) begin
      ds_reg <= DS_IDLE;
      dcnt_reg <= '0;
      dcrc_reg <= 16'h0000;
      byte_reg <= 8'h00;
      tok_reg <= 3'h0;
      buf_full_reg <= 1'b0;
      buf_good_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      pcnt_reg <= '0;
      boff_reg <= '0;
      dat0_pin <= '{o: 1'b1, oe: 1'b0};
    end else begin
      if (pcnt_reg != 0)
        pcnt_reg <= pcnt_reg - 1;
      if (prog_req_reg || (stop_reg && buf_full_reg)) begin
        pcnt_reg <= 32'(PROG_CYCLES);
        buf_full_reg <= 1'b0;
      end
      unique case (ds_reg)
        DS_IDLE: begin
          dat0_pin <= '{o: 1'b1, oe: 1'b0};
          if (buf_full_reg)
            dat0_pin <= '{o: 1'b0, oe: 1'b1};
          dcnt_reg <= '0;
          boff_reg <= '0;
          if (start_read_reg) begin
            ds_reg <= DS_WAIT;
            dcnt_reg <= 32'(ACCESS_CYCLES);
          end else if (start_write_reg)
            ds_reg <= DS_RECV;
          else if (rsp_busy_reg && (pcnt_reg != 0 || stop_reg || prog_req_reg)) begin
            ds_reg <= DS_BUSY;
            dat0_pin <= '{o: 1'b0, oe: ab_reg};
          end
        end
        DS_WAIT: begin
          dcnt_reg <= dcnt_reg - 1;
          if (stop_now) begin
            ds_reg <= DS_TAIL;
            dcnt_reg <= '0;
            dat0_pin <= '{o: 1'b1, oe: 1'b1};
          end else if (dcnt_reg <= 1) begin
            ds_reg <= DS_SEND;
            dcnt_reg <= '0;
            dcrc_reg <= 16'h0000;
            dat0_pin <= '{o: 1'b0, oe: 1'b1};
          end
        end
        DS_SEND: begin
          dcnt_reg <= dcnt_reg + 1;
          if (stop_now) begin
            ds_reg <= DS_TAIL;
            dcnt_reg <= '0;
            dat0_pin <= '{o: 1'b1, oe: 1'b1};
          end else if (dcnt_reg < BLK_BITS) begin
            dat0_pin <= '{o: mem[maddr][7 - dcnt_reg[2:0]], oe: 1'b1};
            dcrc_reg <= crc16_step(dcrc_reg, mem[maddr][7 - dcnt_reg[2:0]]);
          end else if (dcnt_reg < BLK_BITS + 16) begin
            dat0_pin <= '{o: dcrc_reg[15], oe: 1'b1};
            dcrc_reg <= {dcrc_reg[14:0], 1'b0};
          end else begin
            dat0_pin <= '{o: 1'b1, oe: 1'b1};
            if (multi_reg) begin
              ds_reg <= DS_WAIT;
              boff_reg <= boff_reg + 32'(BLOCK_BYTES);
              dcnt_reg <= 32'(mcb_pkg::READ_ACCESS_DELAY_MIN);
            end else
              ds_reg <= DS_IDLE;
          end
        end
        DS_RECV: begin
          dat0_pin <= '{o: 1'b0, oe: buf_full_reg};
          if (stop_reg) begin
            ds_reg <= DS_IDLE;
          end else if (dcnt_reg == 0 && !buf_full_reg) begin
            if (!dat0_i) begin
              dcnt_reg <= 1;
              dcrc_reg <= 16'h0000;
            end
          end else if (dcnt_reg != 0) begin
            dcnt_reg <= dcnt_reg + 1;
            if (dcnt_reg <= BLK_BITS) begin
              byte_reg <= {byte_reg[6:0], dat0_i};
              dcrc_reg <= crc16_step(dcrc_reg, dat0_i);
              if (dcnt_reg[2:0] == 3'h0)
                rxb[(dcnt_reg - 1) >> 3] <= {byte_reg[6:0], dat0_i};
            end else if (dcnt_reg <= BLK_BITS + 16)
              dcrc_reg <= crc16_step(dcrc_reg, dat0_i);
            else begin
              buf_good_reg <= (dcrc_reg == 16'h0000) && dat0_i;
              tok_reg <= ((dcrc_reg == 16'h0000) && dat0_i) ? mcb_pkg::TOKEN_GOOD : mcb_pkg::TOKEN_BAD;
              ds_reg <= DS_TOKEN;
              dcnt_reg <= '0;
            end
          end
        end
        DS_TOKEN: begin
          dcnt_reg <= dcnt_reg + 1;
          if (stop_now) begin
            ds_reg <= DS_TAIL;
            dcnt_reg <= '0;
            dat0_pin <= '{o: 1'b1, oe: 1'b1};
          end else if (dcnt_reg == 0)
            dat0_pin <= '{o: 1'b0, oe: 1'b1};
          else if (dcnt_reg < 4)
            dat0_pin <= '{o: tok_reg[3 - dcnt_reg[1:0]], oe: 1'b1};
          else if (dcnt_reg == 4)
            dat0_pin <= '{o: 1'b1, oe: 1'b1};
          else begin
            // block reaches memory only once its token has gone out
            if (buf_good_reg) begin
              buf_full_reg <= 1'b1;
              boff_reg <= boff_reg + 32'(BLOCK_BYTES);
              for (int i = 0; i < BLOCK_BYTES; i++)
                mem[(addr_reg + boff_reg + 32'(i)) % MEM_BYTES] <= rxb[i];
            end
            dat0_pin <= '{o: 1'b0, oe: buf_good_reg};
            dcnt_reg <= '0;
            ds_reg <= multi_reg ? DS_RECV : DS_IDLE;
            if (!multi_reg && buf_good_reg)
              pcnt_reg <= 32'(PROG_CYCLES);
          end
        end
        DS_TAIL: begin
          // end bit already out; release for the z clocks
          dcnt_reg <= dcnt_reg + 1;
          dat0_pin <= '{o: 1'b1, oe: 1'b0};
          if (dcnt_reg == mcb_pkg::Z_BITS - 1)
            ds_reg <= DS_IDLE;
        end
        DS_BUSY: begin
          dat0_pin <= '{o: 1'b0, oe: ab_reg};
          if (pcnt_reg == 0 && !prog_req_reg && !stop_reg)
            ds_reg <= DS_IDLE;
        end
      endcase
      if (buf_full_reg && pcnt_reg == 1)
        buf_full_reg <= 1'b0;
    end
  end
  assign prog_busy_q = (pcnt_reg != 0);

  // ---------------------------------------------------------------
  // status into the system domain
  // ---------------------------------------------------------------
  logic [4:0] s1_reg, s2_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      busy <= 1'b0;
      card_state <= 4'h0;
    end else begin
      s1_reg <= {prog_busy_q, st_reg};
      s2_reg <= s1_reg;
      busy <= s2_reg[4];
      // take the state word only once two samples agree
      if (s2_reg[3:0] == s1_reg[3:0])
        card_state <= s2_reg[3:0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_id_cmd;
    cmd_done && cmd_ok && is_id && !tx_act_reg;
  endsequence
  a_id_delay_exact: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    s_id_cmd |=> !cmd_pin.oe [*4] ##1 (cmd_pin.oe && !cmd_pin.o))
    else $error("identify reply not at fixed delay");
  a_open_drain: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (tx_act_reg && tx_od_reg && cmd_d.oe) |-> !cmd_d.o)
    else $error("open-drain drove high");
  a_token_good: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (ds_reg == DS_TOKEN && dcnt_reg == 1 && !stop_reg && tok_reg == mcb_pkg::TOKEN_GOOD)
      |=> dat0_pin.o == 1'b0)
    else $error("good token bit wrong");
  a_stop_tail: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (ds_reg == DS_TOKEN && stop_now) |=> (dat0_pin.oe && dat0_pin.o) ##1 !dat0_pin.oe)
    else $error("stop tail wrong");
  a_stop_drop: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (ds_reg == DS_TOKEN && stop_now) |=> $stable(buf_full_reg))
    else $error("cut block kept");
  a_buf_busy: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (ds_reg == DS_RECV && $past(ds_reg) == DS_RECV && $past(buf_full_reg)) |-> dat0_pin.oe && !dat0_pin.o)
    else $error("no busy with full buffer");
  a_read_start: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (ds_reg == DS_WAIT && dcnt_reg == 1 && !stop_now) |=> (dat0_pin.oe && !dat0_pin.o))
    else $error("read start bit missing");
  a_stop_read: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    (ds_reg == DS_SEND && stop_now) |=> ds_reg == DS_TAIL ##1 !dat0_pin.oe)
    else $error("read not stopped");
endmodule

// file: verif/mcb_host.sv
// host controller model for the card command and data0 lines
`timescale 1ns/1ps
module mcb_host (
  input wire logic link_clk, // link clock
  input wire logic cmd_w, // resolved command wire
  input wire logic dat_w, // resolved data0 wire
  output logic cmd_o, // command drive
  output logic cmd_oe, // command drive enable
  output logic dat_o, // data0 drive
  output logic dat_oe // data0 drive enable
);
  // ---------------------------------------------
  // check sums and bus cycles
  // ---------------------------------------------
  initial begin
    cmd_o = 1'b1;
    cmd_oe = 1'b0;
    dat_o = 1'b1;
    dat_oe = 1'b0;
  end
  function automatic logic [6:0] crc7(input logic [39:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  function automatic logic [15:0] crc16(input logic [31:0] v);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((v[i] ^ c[15]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  // drive one frame msb first, launched just after rising edges
  task automatic drive(input logic dl, input logic [63:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge link_clk);
      #1;
      if (dl) begin
        dat_oe = 1'b1;
        dat_o = f[i];
      end else begin
        cmd_oe = 1'b1;
        cmd_o = f[i];
      end
    end
    @(posedge link_clk);
    #1;
    cmd_oe = 1'b0;
    dat_oe = 1'b0;
  endtask
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
    drive(1'b0, {16'h0, 2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h0, bad}, 1'b1}, 48);
  endtask
  // d counts link cycles from the end bit; 80 means no frame seen
  task automatic get_frame(input logic dl, input int n, output int d, output logic [63:0] r);
    d = 0;
    r = '0;
    while (d < 80) begin
      @(negedge link_clk);
      if ((dl ? dat_w : cmd_w) === 1'b0) break;
      d++;
    end
    for (int i = n - 1; i >= 0 && d < 80; i--) begin
      @(negedge link_clk);
      r[i] = dl ? dat_w : cmd_w;
    end
  endtask
  task automatic put_blk(input logic [31:0] w, input logic bad, output int d,
                         output logic [63:0] r);
    repeat (2) @(posedge link_clk);
    drive(1'b1, {14'h0, 1'b0, w, crc16(w) ^ {15'h0, bad}, 1'b1}, 50);
    get_frame(1'b1, 4, d, r);
  endtask
  task automatic gap();
    repeat (8) @(posedge link_clk);
  endtask
endmodule

// file: verif/testbench.sv
// self-checking bench for the card-side bus transfer block
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------
  // clocks, wires and instances
  // ---------------------------------------------
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic saw_pp = 1'b0;
  logic cmd_w, dat_w, h_cmd_o, h_cmd_oe, h_dat_o, h_dat_oe, busy;
  logic [3:0] card_state;
  mcb_pkg::mcb_pin_t cmd_pin, dat0_pin;
  int n_fail = 0;
  int n_checks = 0;
  int d, dd, seed;
  logic [63:0] r, rr;
  logic [31:0] a, wd;
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // both lines pulled up
  assign cmd_w = (cmd_pin.oe ? cmd_pin.o : 1'b1) & (h_cmd_oe ? h_cmd_o : 1'b1);
  assign dat_w = (dat0_pin.oe ? dat0_pin.o : 1'b1) & (h_dat_oe ? h_dat_o : 1'b1);
  always @(negedge link_clk) if (cmd_pin.oe === 1'b1 && cmd_pin.o === 1'b1) saw_pp = 1'b1;
  mcb_card #(.BLOCK_BYTES(4), .PROG_CYCLES(400)) mcb_card_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .link_clk(link_clk), .cmd_i(cmd_w), .cmd_pin(cmd_pin), .dat0_i(dat_w),
    .dat0_pin(dat0_pin), .busy(busy), .card_state(card_state));
  mcb_host mcb_host_i (.link_clk(link_clk), .cmd_w(cmd_w), .dat_w(dat_w), .cmd_o(h_cmd_o),
    .cmd_oe(h_cmd_oe), .dat_o(h_dat_o), .dat_oe(h_dat_oe));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
    mcb_host_i.send_cmd(idx, arg, 1'b0);
    mcb_host_i.get_frame(1'b0, 47, d, r);
    chk(r[46:0], {1'b0, idx, arg, mcb_host_i.crc7({2'b00, idx, arg}), 1'b1});
    mcb_host_i.gap();
  endtask
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 30000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(busy, v);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    seed = $urandom(38);
    repeat (6) @(posedge ref_clk);
    #1;
    chk({busy, card_state}, 5'h00);
    rst_n = 1'b1;
    repeat (6) @(posedge link_clk);
    cmd(mcb_pkg::CMD_SEND_OP_COND, 32'h00ff8000);
    chk(d, 5);
    cmd(mcb_pkg::CMD_ALL_SEND_ID, 32'h0);
    chk(d, 5);
    cmd(mcb_pkg::CMD_SET_ADDR, 32'h00010000);
    chk(d >= 2, 1'b1);
    chk(saw_pp, 1'b0);
    cmd(mcb_pkg::CMD_SELECT, 32'h00010000);
    chk(saw_pp, 1'b1);
    mcb_host_i.send_cmd(mcb_pkg::CMD_STATUS, 32'h00010000, 1'b1);
    mcb_host_i.get_frame(1'b0, 47, d, r);
    chk(d, 80);
    mcb_host_i.gap();
    cmd(mcb_pkg::CMD_BLOCKLEN, 32'h4);
    cmd(mcb_pkg::CMD_BUS_TEST, 32'h0);
    for (int i = 0; i < 4; i++) begin
      a = 32'($urandom_range(255, 0)) << 2;
      wd = (i == 0) ? 32'hffffffff : $urandom();
      cmd(mcb_pkg::CMD_WRITE_SINGLE, a);
      mcb_host_i.put_blk(wd, 1'b0, d, r);
      chk(r[3:0], 4'h5);
      wait_busy(1'b1);
      @(negedge link_clk);
      chk(dat_w, 1'b0);
      wait_busy(1'b0);
      cmd(mcb_pkg::CMD_WRITE_SINGLE, a);
      mcb_host_i.put_blk(~wd, 1'b1, d, r);
      chk(r[3:0], 4'hb);
      repeat (20) @(posedge ref_clk);
      chk(busy, 1'b0);
      mcb_host_i.send_cmd(mcb_pkg::CMD_READ_SINGLE, a, 1'b0);
      fork
        mcb_host_i.get_frame(1'b0, 47, d, r);
        mcb_host_i.get_frame(1'b1, 49, dd, rr);
      join
      chk(dd >= mcb_pkg::READ_ACCESS_DELAY_MIN, 1'b1);
      chk(rr[48:0], {wd, mcb_host_i.crc16(wd), 1'b1});
      mcb_host_i.gap();
    end
    mcb_host_i.send_cmd(mcb_pkg::CMD_READ_MULTI, a, 1'b0);
    mcb_host_i.get_frame(1'b0, 47, d, r);
    mcb_host_i.gap();
    mcb_host_i.send_cmd(mcb_pkg::CMD_STOP, 32'h0, 1'b0);
    repeat (3) @(posedge link_clk);
    @(negedge link_clk);
    chk(dat0_pin.oe, 1'b0);
    mcb_host_i.get_frame(1'b0, 47, d, r);
    mcb_host_i.gap();
    cmd(mcb_pkg::CMD_ERASE_START, 32'h0);
    cmd(mcb_pkg::CMD_ERASE_END, 32'h0);
    cmd(mcb_pkg::CMD_ERASE, 32'h0);
    wait_busy(1'b1);
    @(negedge link_clk);
    chk(dat_w, 1'b0);
    mcb_host_i.send_cmd(mcb_pkg::CMD_SELECT, 32'h0, 1'b0);
    mcb_host_i.get_frame(1'b0, 47, d, r);
    mcb_host_i.gap();
    if (busy === 1'b1) begin
      chk(dat_w, 1'b1);
      cmd(mcb_pkg::CMD_SELECT, 32'h00010000);
      repeat (3) @(negedge link_clk);
      chk(dat_w, 1'b0);
    end
    wait_busy(1'b0);
    end_of_test();
  end
endmodule
